/* ioc_consts.vh */
// constants for the io cell group: layout, register map, fields, reset values
// assumes inclusion by bare name from the design files
`ifndef IOC_CONSTS_VH
`define IOC_CONSTS_VH
`define IOC_CELLS 4
`define IOC_DEL_W 5
`define IOC_DEL_TAPS 32
`define IOC_FIX_DEL_TAP 5'h03
`define IOC_FIFO_W 8
`define IOC_FIFO_D 8
`define IOC_ADR_W 8
`define IOC_ADR_CTRL 8'h00
`define IOC_ADR_STAT 8'h04
`define IOC_ADR_DATA 8'h08
`define IOC_CTRL_RST 32'h00000000
`define IOC_CTL_BYP 0
`define IOC_CTL_FIX 4
`define IOC_CTL_DYN 8
`define IOC_CTL_DDRI 12
`define IOC_CTL_DDRO 16
`define IOC_CTL_TREG 20
`define IOC_CTL_PAIR 24
`define IOC_CTL_SRV 26
`define IOC_CTL_CAP 27
`define IOC_CTL_CLAMP 28
`define IOC_EDGE_LEFT 2'h0
`define IOC_EDGE_TOP 2'h1
`define IOC_EDGE_BOTTOM 2'h2
`define IOC_EDGE_RIGHT 2'h3
`endif

/* ioc_fifo.v */
// small show-ahead fifo with registered read data
// assumes one clock, synchronous active high reset, clock enable freezing all state
`timescale 1ns/1ps
`default_nettype none
module ioc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8
) (
  input wire i_mclk,
  input wire i_reset,
  input wire i_ce,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  output reg o_out_valid,
  input wire i_out_ready,
  output reg [WIDTH-1:0] o_out_data
);
  localparam AW = $clog2(DEPTH);
  localparam [AW:0] FULL_COUNT = DEPTH;
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  reg [AW:0] count_next;
  wire push;
  wire load;
  assign o_in_ready = (count_reg < FULL_COUNT);
  assign push = i_in_valid && o_in_ready;
  // refill the output register when it is empty or being drained
  assign load = (count_reg != {(AW+1){1'b0}}) && (!o_out_valid || i_out_ready);
  always @* begin
    count_next = count_reg;
    case ({push, load})
      2'b10: count_next = count_reg + 1'b1;
      2'b01: count_next = count_reg - 1'b1;
      default: count_next = count_reg;
    endcase
  end
  always @(posedge i_mclk) begin
    if (i_reset) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
      o_out_valid <= 1'b0;
      o_out_data <= {WIDTH{1'b0}};
    end else if (i_ce) begin
      if (push) begin
        mem[wr_ptr_reg] <= i_in_data;
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (load) begin
        o_out_data <= mem[rd_ptr_reg];
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
        o_out_valid <= 1'b1;
      end else if (i_out_ready) begin
        o_out_valid <= 1'b0;
      end
      count_reg <= count_next;
    end
  end
endmodule // ioc_fifo
`default_nettype wire

/* ioc_top.v */
// one io cell group of four io logic cells with a classic wishbone register slave
// assumes pad and core signals synchronous to i_mclk; placement edge is a parameter
`timescale 1ns/1ps
`default_nettype none
`include "ioc_consts.vh"
// Operation
// - input, output and tristate registers per cell
// - four cells form one group
// - pairs drive complementary outputs
// - bypass skips delay and registers
// - fixed delay; bottom edge dynamic select
// - single rate capture on fall output
// - double rate rise and fall streams
// - primary and secondary output data
// - tristate control reaches pad buffer
// - one clock, clock enable gated
// - local set/reset forces programmed value
// - right edge strobe clocks and polarity
// - right edge memory capture logic
// - bottom edge clamp only after configuration, supplies valid
module ioc_top #(
  parameter [1:0] EDGE = `IOC_EDGE_LEFT
) (
  input wire i_mclk,
  input wire i_reset,
  input wire i_ce,
  input wire i_local_sr,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [`IOC_ADR_W-1:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  input wire [`IOC_CELLS-1:0] i_pad_in,
  output wire [`IOC_CELLS-1:0] o_input_bypass_data,
  output wire [`IOC_CELLS-1:0] o_input_bypass_clock,
  output reg [`IOC_CELLS-1:0] o_rise_edge_capture,
  output reg [`IOC_CELLS-1:0] o_fall_or_single_rate_capture,
  input wire [`IOC_CELLS*`IOC_DEL_W-1:0] i_dynamic_delay_select,
  input wire [`IOC_CELLS-1:0] i_core_out_primary,
  input wire [`IOC_CELLS-1:0] i_core_out_secondary,
  input wire [`IOC_CELLS-1:0] i_core_tristate_ctl,
  output wire [`IOC_CELLS-1:0] o_pad_out,
  output wire [`IOC_CELLS-1:0] o_buffer_tristate_out,
  input wire i_strobe_read_clk_shifted,
  input wire i_strobe_write_clk_shifted,
  input wire i_double_rate_capture_polarity,
  input wire i_config_done,
  input wire i_supply_valid,
  output reg o_bus_clamp_en
);
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_ACK = 2'b10;
  localparam IS_BOTTOM = (EDGE == `IOC_EDGE_BOTTOM);
  localparam IS_RIGHT = (EDGE == `IOC_EDGE_RIGHT);

  function hit;
    input [`IOC_ADR_W-1:0] adr;
    input [`IOC_ADR_W-1:0] off;
    begin
      hit = (adr[`IOC_ADR_W-1:2] == off[`IOC_ADR_W-1:2]);
    end
  endfunction

  function pick_tap;
    input [`IOC_DEL_TAPS-1:0] chain;
    input [`IOC_DEL_W-1:0] sel;
    begin
      pick_tap = chain[sel];
    end
  endfunction

  reg [1:0] state_reg;
  reg [31:0] ctrl_reg;
  reg [`IOC_CELLS-1:0] cap_neg_reg;
  reg [`IOC_CELLS-1:0] out_pri_reg;
  reg [`IOC_CELLS-1:0] out_sec_reg;
  reg [`IOC_CELLS-1:0] tri_reg;
  reg [`IOC_FIFO_W-1:0] word_reg;
  reg word_valid_reg;
  reg [31:0] rd_mux;
  reg [`IOC_CELLS-1:0] pri_src;
  reg [`IOC_CELLS-1:0] sec_src;
  reg [`IOC_CELLS-1:0] tri_src;
  wire [`IOC_CELLS-1:0] dly_data;
  wire [`IOC_CELLS-1:0] byp;
  wire [`IOC_CELLS-1:0] ddr_in;
  wire [`IOC_CELLS-1:0] ddr_out;
  wire [`IOC_CELLS-1:0] treg;
  wire [1:0] pair;
  wire sr_val;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [`IOC_FIFO_W-1:0] fifo_out_data;
  wire fifo_pop;
  wire wr_ctrl;

  assign byp = ctrl_reg[`IOC_CTL_BYP +: `IOC_CELLS];
  assign ddr_in = ctrl_reg[`IOC_CTL_DDRI +: `IOC_CELLS];
  assign ddr_out = ctrl_reg[`IOC_CTL_DDRO +: `IOC_CELLS];
  assign treg = ctrl_reg[`IOC_CTL_TREG +: `IOC_CELLS];
  assign pair = ctrl_reg[`IOC_CTL_PAIR +: 2];
  assign sr_val = ctrl_reg[`IOC_CTL_SRV];

  // raw pad straight to core, no delay, no register
  assign o_input_bypass_data = i_pad_in & byp;
  assign o_input_bypass_clock = i_pad_in & byp;

  // odd cell of a pair takes the inverse of its even neighbour's data and a copy of its tristate
  always @* begin
    pri_src = i_core_out_primary;
    sec_src = i_core_out_secondary;
    tri_src = i_core_tristate_ctl;
    if (pair[0]) begin
      pri_src[1] = ~i_core_out_primary[0];
      sec_src[1] = ~i_core_out_secondary[0];
      tri_src[1] = i_core_tristate_ctl[0];
    end
    if (pair[1]) begin
      pri_src[3] = ~i_core_out_primary[2];
      sec_src[3] = ~i_core_out_secondary[2];
      tri_src[3] = i_core_tristate_ctl[2];
    end
  end

  // four identical cells in the group
  genvar c;
  generate
    for (c = 0; c < `IOC_CELLS; c = c + 1) begin : g_cell
      reg [`IOC_DEL_TAPS-1:0] chain_reg;
      wire [`IOC_DEL_W-1:0] dsel;
      wire fix_en;
      wire dyn_en;
      assign dsel = i_dynamic_delay_select[c*`IOC_DEL_W +: `IOC_DEL_W];
      assign fix_en = ctrl_reg[`IOC_CTL_FIX + c];
      // dynamic select only exists on the bottom edge
      assign dyn_en = ctrl_reg[`IOC_CTL_DYN + c] && IS_BOTTOM;
      assign dly_data[c] = dyn_en ? pick_tap(chain_reg, dsel) :
                           fix_en ? pick_tap(chain_reg, `IOC_FIX_DEL_TAP) : i_pad_in[c];
      always @(posedge i_mclk) begin
        if (i_reset) begin
          chain_reg <= {`IOC_DEL_TAPS{1'b0}};
        end else if (i_ce) begin
          chain_reg <= {chain_reg[`IOC_DEL_TAPS-2:0], i_pad_in[c]};
        end
      end

      // input block: falling edge register of the double rate pair
      always @(negedge i_mclk) begin
        if (i_reset) begin
          cap_neg_reg[c] <= 1'b0;
        end else if (i_ce) begin
          if (i_local_sr) begin
            cap_neg_reg[c] <= sr_val;
          end else if (!IS_RIGHT || i_strobe_read_clk_shifted) begin
            cap_neg_reg[c] <= dly_data[c];
          end
        end
      end

      // input block rising edge; fall stream retimed onto the rising edge
      always @(posedge i_mclk) begin
        if (i_reset) begin
          o_rise_edge_capture[c] <= 1'b0;
          o_fall_or_single_rate_capture[c] <= 1'b0;
        end else if (i_ce) begin
          if (i_local_sr) begin
            o_rise_edge_capture[c] <= sr_val;
            o_fall_or_single_rate_capture[c] <= sr_val;
          end else if (!ddr_in[c]) begin
            o_fall_or_single_rate_capture[c] <= dly_data[c];
          end else if (IS_RIGHT && i_double_rate_capture_polarity) begin
            // polarity input picks which edge is first; the swapped capture does not wait for the read strobe
            o_rise_edge_capture[c] <= cap_neg_reg[c];
            o_fall_or_single_rate_capture[c] <= dly_data[c];
          end else if (!IS_RIGHT || i_strobe_read_clk_shifted) begin
            o_rise_edge_capture[c] <= dly_data[c];
            o_fall_or_single_rate_capture[c] <= cap_neg_reg[c];
          end
        end
      end

      // output and tristate blocks, rising edge
      always @(posedge i_mclk) begin
        if (i_reset) begin
          out_pri_reg[c] <= 1'b0;
          tri_reg[c] <= 1'b1;
        end else if (i_ce) begin
          if (i_local_sr) begin
            out_pri_reg[c] <= sr_val;
            tri_reg[c] <= sr_val;
          end else begin
            if (!IS_RIGHT || !ddr_out[c] || i_strobe_write_clk_shifted) begin
              out_pri_reg[c] <= pri_src[c];
            end
            tri_reg[c] <= tri_src[c];
          end
        end
      end

      // secondary data held on the falling edge, used only in double rate
      always @(negedge i_mclk) begin
        if (i_reset) begin
          out_sec_reg[c] <= 1'b0;
        end else if (i_ce) begin
          if (i_local_sr) begin
            out_sec_reg[c] <= sr_val;
          end else if (!IS_RIGHT || i_strobe_write_clk_shifted) begin
            out_sec_reg[c] <= sec_src[c];
          end
        end
      end

      // clock-level mux is the only way to get two bits per period out
      assign o_pad_out[c] = (ddr_out[c] && !i_mclk) ? out_sec_reg[c] : out_pri_reg[c];
      assign o_buffer_tristate_out[c] = treg[c] ? tri_reg[c] : tri_src[c];
    end
  endgenerate

  // capture words toward the fifo; holding word_reg stalls sampling when full
  ioc_fifo #(
    .WIDTH(`IOC_FIFO_W),
    .DEPTH(`IOC_FIFO_D)
  ) u_fifo (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_in_valid(word_valid_reg),
    .o_in_ready(fifo_in_ready),
    .i_in_data(word_reg),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_out_data)
  );

  always @(posedge i_mclk) begin
    if (i_reset) begin
      word_reg <= {`IOC_FIFO_W{1'b0}};
      word_valid_reg <= 1'b0;
    end else if (i_ce) begin
      if (!word_valid_reg || fifo_in_ready) begin
        word_reg <= {o_fall_or_single_rate_capture, o_rise_edge_capture};
        word_valid_reg <= ctrl_reg[`IOC_CTL_CAP];
      end
    end
  end

  // bottom edge bus clamp held off until configured with good supplies
  always @(posedge i_mclk) begin
    if (i_reset) begin
      o_bus_clamp_en <= 1'b0;
    end else if (i_ce) begin
      o_bus_clamp_en <= ctrl_reg[`IOC_CTL_CLAMP] && IS_BOTTOM && i_config_done && i_supply_valid;
    end
  end

  always @* begin
    rd_mux = 32'h00000000;
    if (hit(i_wb_adr, `IOC_ADR_CTRL)) begin
      rd_mux = ctrl_reg;
    end else if (hit(i_wb_adr, `IOC_ADR_STAT)) begin
      rd_mux[3:0] = o_fall_or_single_rate_capture;
      rd_mux[7:4] = o_rise_edge_capture;
      rd_mux[11:8] = o_buffer_tristate_out;
      rd_mux[12] = fifo_out_valid;
      rd_mux[13] = !fifo_in_ready;
      rd_mux[14] = o_bus_clamp_en;
      rd_mux[15] = i_config_done && i_supply_valid;
    end else if (hit(i_wb_adr, `IOC_ADR_DATA)) begin
      rd_mux[`IOC_FIFO_W-1:0] = fifo_out_data & {`IOC_FIFO_W{fifo_out_valid}};
      rd_mux[8] = fifo_out_valid;
    end
  end

  // write and pop take effect at the edge where the master sees ack
  assign wr_ctrl = (state_reg == ST_ACK) && i_wb_cyc && i_wb_stb && i_wb_we && hit(i_wb_adr, `IOC_ADR_CTRL);
  assign fifo_pop = i_ce && (state_reg == ST_ACK) && i_wb_cyc && i_wb_stb && !i_wb_we &&
                    hit(i_wb_adr, `IOC_ADR_DATA) && fifo_out_valid;

  integer b;
  always @(posedge i_mclk) begin
    if (i_reset) begin
      state_reg <= ST_IDLE;
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
      ctrl_reg <= `IOC_CTRL_RST;
    end else if (i_ce) begin
      case (state_reg)
        ST_IDLE: begin
          if (i_wb_cyc && i_wb_stb) begin
            o_wb_ack <= 1'b1;
            o_wb_dat <= i_wb_we ? 32'h00000000 : rd_mux;
            state_reg <= ST_ACK;
          end
        end
        ST_ACK: begin
          o_wb_ack <= 1'b0;
          state_reg <= ST_IDLE;
          if (wr_ctrl) begin
            for (b = 0; b < 4; b = b + 1) begin
              if (i_wb_sel[b]) begin
                ctrl_reg[b*8 +: 8] <= i_wb_dat[b*8 +: 8];
              end
            end
          end
        end
        default: begin
          o_wb_ack <= 1'b0;
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // ioc_top
`default_nettype wire

/* ioc_top_asserts.sv */
// port assertions for the io cell group
// assumes binding onto ioc_top, one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module ioc_top_chk (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_local_sr,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic o_wb_ack,
  input wire logic [31:0] o_wb_dat,
  input wire logic [3:0] i_pad_in,
  input wire logic [3:0] o_input_bypass_data,
  input wire logic [3:0] o_input_bypass_clock,
  input wire logic [3:0] o_rise_edge_capture,
  input wire logic [3:0] o_fall_or_single_rate_capture,
  input wire logic [3:0] o_pad_out,
  input wire logic i_config_done,
  input wire logic i_supply_valid,
  input wire logic o_bus_clamp_en
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  AST_ACK_PULSE: assert property (o_wb_ack && i_ce |=> !o_wb_ack)
    else $error("ack held past one cycle");
  AST_ACK_CAUSE: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
    else $error("ack without request");
  AST_ACK_CE: assert property (o_wb_ack |-> $past(i_ce))
    else $error("ack while clock enable low");
  AST_DAT_HOLD: assert property ($changed(o_wb_dat) |-> o_wb_ack)
    else $error("read data moved without ack");
  AST_BYP_SUB: assert property ((o_input_bypass_data & ~i_pad_in) == 4'h0)
    else $error("bypass data not from pad");
  AST_BYP_CLK: assert property (o_input_bypass_clock == o_input_bypass_data)
    else $error("bypass clock differs from bypass data");
  AST_CLAMP_GATE: assert property (o_bus_clamp_en |-> $past(i_config_done && i_supply_valid))
    else $error("clamp before configuration and supplies");
  AST_FREEZE: assert property (!i_ce && !i_local_sr |=> $stable(o_rise_edge_capture)
    && $stable(o_fall_or_single_rate_capture) && $stable(o_pad_out))
    else $error("capture moved with clock enable low");
  AST_SR_FORCE: assert property ((i_local_sr && i_ce) [*2] |->
    (o_rise_edge_capture == o_fall_or_single_rate_capture) && (o_pad_out == o_rise_edge_capture)
    && (o_pad_out == 4'h0 || o_pad_out == 4'hf))
    else $error("set reset did not force a common value");
endmodule // ioc_top_chk
bind ioc_top ioc_top_chk i_chk (.i_mclk(i_mclk), .i_reset(i_reset), .i_ce(i_ce), .i_local_sr(i_local_sr),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat), .i_pad_in(i_pad_in),
  .o_input_bypass_data(o_input_bypass_data), .o_input_bypass_clock(o_input_bypass_clock),
  .o_rise_edge_capture(o_rise_edge_capture), .o_fall_or_single_rate_capture(o_fall_or_single_rate_capture),
  .o_pad_out(o_pad_out), .i_config_done(i_config_done), .i_supply_valid(i_supply_valid),
  .o_bus_clamp_en(o_bus_clamp_en));
`default_nettype wire

/* ioc_pad_model.sv */
// pad buffers and external drivers for four cells
// assumes tristate high means the cell does not drive its pad
`timescale 1ns/1ps
`default_nettype none
module ioc_pad_model (
  input wire logic i_mclk,
  input wire logic [3:0] i_pad_out,
  input wire logic [3:0] i_tristate,
  input wire logic [3:0] i_val_rise,
  input wire logic [3:0] i_val_fall,
  output logic [3:0] o_pad
);
  logic [3:0] ext_reg;
  // changes on both edges so each edge sees its own stream
  always @(i_mclk) ext_reg <= i_mclk ? i_val_fall : i_val_rise;
  assign o_pad = (i_tristate & ext_reg) | (~i_tristate & i_pad_out);
endmodule // ioc_pad_model
`default_nettype wire

/* ioc_top_bench.sv */
// self-checking bench for one io cell group on the bottom edge
// assumes ioc_top, ioc_fifo, pad model and checker compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "ioc_consts.vh"
module ioc_top_bench;
  logic i_mclk, i_reset, ce, sr, cyc, stb, we, ack, done, valid, clamp;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [3:0] sel, pad, byp_d, byp_c, rise, fall, prim, sec, tri_c, pad_out, tri_out, va, vb;
  logic [19:0] dsel;
  integer fails, checks_done, i, n;
  ioc_top #(.EDGE(`IOC_EDGE_BOTTOM)) i_dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_ce(ce), .i_local_sr(sr),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_pad_in(pad), .o_input_bypass_data(byp_d), .o_input_bypass_clock(byp_c),
    .o_rise_edge_capture(rise), .o_fall_or_single_rate_capture(fall), .i_dynamic_delay_select(dsel),
    .i_core_out_primary(prim), .i_core_out_secondary(sec), .i_core_tristate_ctl(tri_c), .o_pad_out(pad_out),
    .o_buffer_tristate_out(tri_out), .i_strobe_read_clk_shifted(1'b0), .i_strobe_write_clk_shifted(1'b0),
    .i_double_rate_capture_polarity(1'b0), .i_config_done(done), .i_supply_valid(valid), .o_bus_clamp_en(clamp));
  ioc_pad_model i_pads (.i_mclk(i_mclk), .i_pad_out(pad_out), .i_tristate(tri_out), .i_val_rise(va),
    .i_val_fall(vb), .o_pad(pad));
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input [31:0] s, input [31:0] e);
    checks_done = checks_done + 1;
    if (s !== e) begin
      fails = fails + 1;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task cy(input integer k);
    repeat (k) @(posedge i_mclk);
  endtask
  // no fixed answer time assumed; the watchdog bounds the wait
  task wb(input [7:0] a, input w, input [31:0] d);
    @(posedge i_mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    @(posedge i_mclk);
    while (ack !== 1'b1) @(posedge i_mclk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task t_regs;
    wb(8'h00, 1'b0, 32'h0);
    chk(q, `IOC_CTRL_RST);
    wb(8'h04, 1'b1, 32'hffffffff);
    wb(8'hfc, 1'b0, 32'h0);
    chk(q, 32'h0);
    wb(8'h00, 1'b0, 32'h0);
    chk(q, 32'h0);
    chk(tri_out, tri_c);
  endtask
  task t_cap;
    va <= 4'h6;
    vb <= 4'h6;
    wb(8'h00, 1'b1, 32'hf);
    cy(1);
    #1 chk({byp_d, byp_c}, 8'h66);
    wb(8'h00, 1'b1, 32'h0);
    cy(2);
    #1 chk(fall, 4'h6);
    cy(1);
    ce <= 1'b0;
    va <= 4'ha;
    vb <= 4'ha;
    cy(3);
    #1 chk(fall, 4'h6);
    cy(1);
    ce <= 1'b1;
    cy(2);
    #1 chk(fall, 4'ha);
    wb(8'h00, 1'b1, 32'hf0);
    cy(8);
    va <= 4'h0;
    vb <= 4'h0;
    cy(3);
    #1 chk(fall, 4'ha);
    cy(2);
    #1 chk(fall, 4'h0);
    // bottom edge: dynamic tap 1 adds two edges over the plain capture
    cy(1);
    dsel <= {4{5'h01}};
    wb(8'h00, 1'b1, 32'hf00);
    cy(4);
    va <= 4'h3;
    vb <= 4'h3;
    cy(2);
    #1 chk(fall, 4'h0);
    cy(1);
    #1 chk(fall, 4'h3);
    va <= 4'h5;
    vb <= 4'ha;
    wb(8'h00, 1'b1, 32'hf000);
    cy(3);
    #1 chk({rise, fall}, 8'h5a);
  endtask
  task t_out;
    prim <= 4'h3;
    sec <= 4'hc;
    wb(8'h00, 1'b1, 32'hf0000);
    cy(2);
    #5 chk(pad_out, 4'h3);
    @(negedge i_mclk);
    #5 chk(pad_out, 4'hc);
    cy(1);
    prim <= 4'h1;
    wb(8'h00, 1'b1, 32'h03000000);
    cy(2);
    #1 chk(pad_out, 4'h9);
    wb(8'h00, 1'b1, 32'h00f00000);
    cy(2);
    tri_c <= 4'h0;
    #1 chk(tri_out, 4'hf);
    cy(1);
    #1 chk(tri_out, 4'h0);
    cy(1);
    tri_c <= 4'hf;
    va <= 4'h0;
    vb <= 4'h0;
    wb(8'h00, 1'b1, 32'h04000000);
    cy(1);
    sr <= 1'b1;
    cy(2);
    #1 chk({rise, fall, pad_out}, 12'hfff);
    cy(1);
    sr <= 1'b0;
  endtask
  task t_clamp;
    valid <= 1'b1;
    wb(8'h00, 1'b1, 32'h10000000);
    cy(3);
    #1 chk(clamp, 1'b0);
    cy(1);
    done <= 1'b1;
    cy(2);
    #1 chk(clamp, 1'b1);
    cy(1);
    valid <= 1'b0;
    cy(2);
    #1 chk(clamp, 1'b0);
  endtask
  // fill until full, then drain slowly through the data register
  task t_fifo;
    va <= 4'h5;
    vb <= 4'ha;
    wb(8'h00, 1'b1, 32'hf000);
    cy(4);
    wb(8'h00, 1'b1, 32'h0800f000);
    cy(16);
    wb(8'h04, 1'b0, 32'h0);
    chk(q[13], 1'b1);
    wb(8'h00, 1'b1, 32'hf000);
    n = 0;
    for (i = 0; i < 14; i = i + 1) begin
      wb(8'h08, 1'b0, 32'h0);
      if (q[8] === 1'b1) begin
        chk(q[7:0], 8'ha5);
        n = n + 1;
      end
    end
    chk(n >= 8, 1'b1);
    wb(8'h04, 1'b0, 32'h0);
    chk(q[12], 1'b0);
  endtask
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  initial begin
    fails = 0;
    checks_done = 0;
    {i_reset, ce, tri_c} = 6'h3f;
    {sr, cyc, stb, we, done, valid, adr, wdat, sel} = 0;
    {prim, sec, va, vb} = 16'h0;
    dsel = 20'h00000;
    cy(3);
    i_reset <= 1'b0;
    t_regs;
    t_cap;
    t_out;
    t_clamp;
    t_fifo;
    close_out;
  end
  // whole run is near 180 cycles
  initial begin
    cy(5000);
    fails = fails + 1;
    close_out;
  end
endmodule // ioc_top_bench
`default_nettype wire
